// ---- dsss_plcp_defs.vh ----
/*
 * Constants for the DSSS preamble/header framer: register byte offsets,
 * field positions, reset values, coding constants and AXI response codes.
 * Assumes it is included by bare name from the design file.
 */
`ifndef DSSS_PLCP_DEFS_VH
`define DSSS_PLCP_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define A_ROT_SENSE 8'h00
`define A_SHORT_LEN 8'h04
`define A_LONG_LEN 8'h08
`define A_TX_SETUP 8'h0C
`define A_SERVICE 8'h10
`define A_LEN_HIGH 8'h14
`define A_LEN_LOW 8'h18
`define A_RX_SIGNAL 8'h1C
`define A_RX_HDR_STAT 8'h20
`define A_SCR_CTRL 8'h24
`define A_LONG_SEED 8'h28
`define A_SHORT_SEED 8'h2C
`define A_TX_MODE 8'h30

// ****************************************
// reset values
// ****************************************
`define RST_SHORT_LEN 8'h38
`define RST_LONG_LEN 8'h80
`define RST_LONG_SEED 7'h1B
`define RST_SHORT_SEED 7'h6C

// ****************************************
// field positions
// ****************************************
`define TX_REV_BIT 6
`define RX_REV_BIT 7
`define SCR_DIS_BIT 2
`define SVC_LOCK_BIT 2
`define TOUT_BIT 0
`define SIG_ERR_BIT 1
`define CRC_ERR_BIT 2
`define RX_RATE_LSB 6

// ****************************************
// rate codes and coding constants
// ****************************************
`define RATE_1M 2'h0
`define RATE_2M 2'h1
`define RATE_5M5 2'h2
`define RATE_11M 2'h3
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF
`define SFD_LONG 16'hF3A0
`define BARKER_WORD 11'h712
`define SFD_LAST 16'h000F
`define HDR_LAST 16'h002F
`define SFD_MARGIN 16'h0010
`define INIT_LAST 16'h0006
`define TAIL_SYMS 16'h0004
`define CHIP_LAST 4'hA

// ****************************************
// AXI responses
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- dsss_plcp_framer_scrambler.v ----
/*
 * DSSS physical-layer preamble/header framer and checker with scrambler,
 * DBPSK/DQPSK differential coding and Barker spreading, AXI4-Lite registers.
 * Assumes: one clock aclk, enables arrive from pins, payload bits and received
 * symbol decisions come from logic on aclk; CCK chip coding lives elsewhere.
 */
//
// Notes on behaviour
// - no valid packet is reported without the 16-bit start delimiter found
// - long or short preamble auto-detected; delimiter time-out starts after descrambler fill
// - rate code: 00 1M DBPSK, 01 2M DQPSK, 10 5.5M CCK, 11 11M CCK
// - signal field decoded; demodulation switches to its rate after the header
// - service MSB resolves 11M length ambiguity; bit 2 marks locked oscillators
// - length field is payload duration in microseconds from two registers
// - header CRC mismatch sets status bit 2, drops data ready, reacquires
// - header check is complemented remainder by x^16+x^12+x^5+1
// - CRC preset to ones, fed before scrambling, sent MSB first
// - short preamble length register, 38h standard
// - long preamble length register, 80h standard
// - service field comes from its own register
// - payload sent unaltered in order, then dummy tail bits
// - preamble, header and data scrambled by 7-bit self-synchronizing register
// - scrambler bypassed when control bit 2 is one
// - transmit seed chosen from long or short seed register
// - DBPSK for 1M data and long headers, same value on I and Q after a long preamble
// - DQPSK dibits 00 0, 01 +90, 11 +180, 10 -90 degrees
// - rotation counterclockwise; bits 6 and 7 reverse transmit and receive
// - I and Q multiplied by 11-chip Barker word; 2M splits bits over I, Q
// - long preamble is ones then delimiter, always DBPSK
// - short preamble is zeros then reversed delimiter; header at 2M
`timescale 1ns/1ns
`include "dsss_plcp_defs.vh"
module dsss_plcp_framer_scrambler #(
    parameter [7:0] CHIP_DIV = 8'h02,
    parameter [15:0] SFD_VALUE = `SFD_LONG,
    parameter [10:0] BARKER = `BARKER_WORD,
    parameter [15:0] TAIL_SYMS = `TAIL_SYMS
) (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire transmit_enable,
    input wire tx_data_bit,
    output wire tx_data_req,
    output reg tx_i,
    output reg tx_q,
    output reg tx_chip_valid,
    input wire receive_enable,
    input wire rx_acquired,
    input wire rx_sym_valid,
    input wire rx_sym_i,
    input wire rx_sym_q,
    output reg rx_data_bit,
    output reg rx_data_valid,
    output reg rx_data_ready,
    output reg [1:0] rx_rate
);

localparam T_IDLE = 3'd0, T_PRE = 3'd1, T_SFD = 3'd2, T_HDR = 3'd3;
localparam T_DATA = 3'd4, T_TAIL = 3'd5, T_DONE = 3'd6;
localparam R_IDLE = 3'd0, R_INIT = 3'd1, R_SFD = 3'd2, R_HDR = 3'd3;
localparam R_CHK = 3'd4, R_DATA = 3'd5;

// ****************************************
// helpers
// ****************************************
function [15:0] crc_calc;
    input [31:0] v;
    reg [15:0] c;
    integer i;
    begin
        c = `CRC_INIT;
        for (i = 0; i < 32; i = i + 1) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? `CRC_POLY : 16'h0000);
        end
        crc_calc = ~c;
    end
endfunction

function [15:0] rev16;
    input [15:0] v;
    integer i;
    begin
        rev16 = 16'h0000;
        for (i = 0; i < 16; i = i + 1) begin
            rev16[i] = v[15 - i];
        end
    end
endfunction

// ****************************************
// registers and AXI4-Lite slave
// ****************************************
reg [7:0] rot_sense, short_len, long_len, svc_val, len_hi, len_lo;
reg [1:0] tx_rate;
reg [2:0] hdr_stat;
reg scr_dis, tx_short;
reg [6:0] long_seed, short_seed;
reg aw_hold, w_hold, w_strb0;
reg [7:0] aw_a, w_d;
reg [7:0] rd_byte;
reg rd_hit, wr_hit;

assign awready = ce & ~aw_hold & ~bvalid;
assign wready = ce & ~w_hold & ~bvalid;
wire aw_t = awvalid & awready;
wire w_t = wvalid & wready;
wire [7:0] wa = aw_hold ? aw_a : awaddr;
wire [7:0] wd = w_hold ? w_d : wdata[7:0];
wire ws = w_hold ? w_strb0 : wstrb[0];
wire do_wr = ce & ~bvalid & (aw_hold | aw_t) & (w_hold | w_t);
wire wr_en = do_wr & ws;
assign arready = ce & ~rvalid;
wire [2:0] stat_set;
wire [2:0] stat_clr = (wr_en && wa == `A_RX_HDR_STAT) ? wd[2:0] : 3'h0;

always @* begin
    wr_hit = 1'b1;
    case (wa)
        `A_ROT_SENSE, `A_SHORT_LEN, `A_LONG_LEN, `A_TX_SETUP, `A_SERVICE, `A_LEN_HIGH,
        `A_LEN_LOW, `A_RX_SIGNAL, `A_RX_HDR_STAT, `A_SCR_CTRL, `A_LONG_SEED,
        `A_SHORT_SEED, `A_TX_MODE: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
    endcase
end

always @* begin
    rd_hit = 1'b1;
    case (araddr)
        `A_ROT_SENSE: rd_byte = rot_sense;
        `A_SHORT_LEN: rd_byte = short_len;
        `A_LONG_LEN: rd_byte = long_len;
        `A_TX_SETUP: rd_byte = {6'h00, tx_rate};
        `A_SERVICE: rd_byte = svc_val;
        `A_LEN_HIGH: rd_byte = len_hi;
        `A_LEN_LOW: rd_byte = len_lo;
        `A_RX_SIGNAL: rd_byte = {rx_rate, 6'h00};
        `A_RX_HDR_STAT: rd_byte = {5'h00, hdr_stat};
        `A_SCR_CTRL: rd_byte = {5'h00, scr_dis, 2'h0};
        `A_LONG_SEED: rd_byte = {1'b0, long_seed};
        `A_SHORT_SEED: rd_byte = {1'b0, short_seed};
        `A_TX_MODE: rd_byte = {7'h00, tx_short};
        default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        aw_a <= 8'h00;
        w_d <= 8'h00;
        w_strb0 <= 1'b0;
        bvalid <= 1'b0;
        bresp <= `RESP_OKAY;
        rvalid <= 1'b0;
        rresp <= `RESP_OKAY;
        rdata <= 32'h00000000;
        rot_sense <= 8'h00;
        short_len <= `RST_SHORT_LEN;
        long_len <= `RST_LONG_LEN;
        tx_rate <= `RATE_1M;
        svc_val <= 8'h00;
        len_hi <= 8'h00;
        len_lo <= 8'h00;
        hdr_stat <= 3'h0;
        scr_dis <= 1'b0;
        long_seed <= `RST_LONG_SEED;
        short_seed <= `RST_SHORT_SEED;
        tx_short <= 1'b0;
    end else if (ce) begin
        if (do_wr) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else begin
            if (aw_t) begin
                aw_hold <= 1'b1;
                aw_a <= awaddr;
            end
            if (w_t) begin
                w_hold <= 1'b1;
                w_d <= wdata[7:0];
                w_strb0 <= wstrb[0];
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
        if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, rd_byte};
            rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
        // event wins over a clear in the same cycle
        hdr_stat <= (hdr_stat & ~stat_clr) | stat_set;
        if (wr_en) begin
            case (wa)
                `A_ROT_SENSE: rot_sense <= wd;
                `A_SHORT_LEN: short_len <= wd;
                `A_LONG_LEN: long_len <= wd;
                `A_TX_SETUP: tx_rate <= wd[1:0];
                `A_SERVICE: svc_val <= wd;
                `A_LEN_HIGH: len_hi <= wd;
                `A_LEN_LOW: len_lo <= wd;
                `A_SCR_CTRL: scr_dis <= wd[`SCR_DIS_BIT];
                `A_LONG_SEED: long_seed <= wd[6:0];
                `A_SHORT_SEED: short_seed <= wd[6:0];
                `A_TX_MODE: tx_short <= wd[0];
                default: ;
            endcase
        end
    end
end

// ****************************************
// pin synchronisers
// ****************************************
reg txe1, txe2, txe_q, rxe1, rxe2;
always @(posedge aclk) begin
    if (!aresetn) begin
        txe1 <= 1'b0;
        txe2 <= 1'b0;
        txe_q <= 1'b0;
        rxe1 <= 1'b0;
        rxe2 <= 1'b0;
    end else if (ce) begin
        txe1 <= transmit_enable;
        txe2 <= txe1;
        txe_q <= txe2;
        rxe1 <= receive_enable;
        rxe2 <= rxe1;
    end
end

// ****************************************
// transmit framer, scrambler, coder, spreader
// ****************************************
reg [2:0] tst;
reg [15:0] tcnt;
reg [6:0] tscr;
reg [47:0] hsr;
reg sh;
reg [7:0] div;
reg [3:0] chip;
reg have, pend, ptwo, pa, pb;
reg [1:0] tph;
wire [15:0] pre_len = {8'h00, sh ? short_len : long_len};
wire [15:0] dlen = {len_hi, len_lo};
wire [15:0] sfd_tx = sh ? rev16(SFD_VALUE) : SFD_VALUE;
wire two_now = (tst == T_HDR && sh) || ((tst == T_DATA || tst == T_TAIL) && tx_rate != `RATE_1M);
wire sym_start = div == 8'h00 && chip == 4'h0;
wire fetch_a = tst != T_IDLE && tst != T_DONE && sym_start;
wire fetch_b = tst != T_IDLE && pend && ptwo && div == 8'h00 && chip == 4'h1;
wire fetch = fetch_a | fetch_b;
wire last_bit = (fetch_a & ~two_now) | fetch_b;
wire sym_end = div == CHIP_DIV - 8'h01 && chip == `CHIP_LAST;
// preamble ones for long and zeros for short, payload passes untouched
wire src_bit = tst == T_PRE ? ~sh : tst == T_SFD ? sfd_tx[tcnt[3:0]] :
    tst == T_HDR ? hsr[0] : tst == T_DATA ? tx_data_bit : 1'b1;
wire scr_bit = scr_dis ? src_bit : src_bit ^ tscr[3] ^ tscr[6];
wire [1:0] inc0 = ptwo ? {pa, pa ^ pb} : {pa, 1'b0};
wire [1:0] inc = rot_sense[`TX_REV_BIT] ? 2'h0 - inc0 : inc0;
wire [7:0] sig_tx = {6'h00, tx_rate};
wire [7:0] svc_tx = svc_val | 8'h04;
wire [31:0] hdr_tx = {dlen, svc_tx, sig_tx};
assign tx_data_req = ce & fetch & (tst == T_DATA);

always @(posedge aclk) begin
    if (!aresetn) begin
        tst <= T_IDLE;
        tcnt <= 16'h0000;
        tscr <= 7'h00;
        hsr <= 48'h000000000000;
        sh <= 1'b0;
        div <= 8'h00;
        chip <= 4'h0;
        {have, pend, ptwo, pa, pb} <= 5'h00;
        tph <= 2'h0;
        tx_i <= 1'b0;
        tx_q <= 1'b0;
        tx_chip_valid <= 1'b0;
    end else if (ce) begin
        tx_i <= have & (tph[1] ^ tph[0] ^ BARKER[chip]);
        tx_q <= have & (tph[1] ^ BARKER[chip]);
        tx_chip_valid <= have;
        if (!txe2) begin
            // enable low ends the packet at once, including the tail
            tst <= T_IDLE;
            have <= 1'b0;
            pend <= 1'b0;
        end else if (tst == T_IDLE) begin
            if (!txe_q) begin
                tst <= T_PRE;
                tcnt <= 16'h0000;
                sh <= tx_short;
                tscr <= tx_short ? short_seed : long_seed;
                hsr <= {rev16(crc_calc(hdr_tx)), hdr_tx};
                div <= 8'h00;
                chip <= 4'h0;
                tph <= 2'h0;
            end
        end else begin
            div <= (div == CHIP_DIV - 8'h01) ? 8'h00 : div + 8'h01;
            if (div == CHIP_DIV - 8'h01) begin
                chip <= (chip == `CHIP_LAST) ? 4'h0 : chip + 4'h1;
            end
            if (fetch) begin
                tscr <= {tscr[5:0], scr_bit};
            end
            if (fetch_a) begin
                pa <= scr_bit;
                ptwo <= two_now;
                pend <= 1'b1;
            end
            if (fetch_b) begin
                pb <= scr_bit;
            end
            if (sym_end) begin
                have <= pend;
                pend <= 1'b0;
                if (pend) begin
                    tph <= tph + inc;
                end
            end
            case (tst)
                T_PRE: if (fetch) begin
                    tcnt <= (tcnt == pre_len - 16'h0001) ? 16'h0000 : tcnt + 16'h0001;
                    if (tcnt == pre_len - 16'h0001) tst <= T_SFD;
                end
                T_SFD: if (fetch) begin
                    tcnt <= (tcnt == `SFD_LAST) ? 16'h0000 : tcnt + 16'h0001;
                    if (tcnt == `SFD_LAST) tst <= T_HDR;
                end
                T_HDR: if (fetch) begin
                    hsr <= {1'b0, hsr[47:1]};
                    tcnt <= (tcnt == `HDR_LAST) ? 16'h0000 : tcnt + 16'h0001;
                    if (tcnt == `HDR_LAST) tst <= (dlen == 16'h0000) ? T_TAIL : T_DATA;
                end
                T_DATA: if (last_bit) begin
                    tcnt <= (tcnt == dlen - 16'h0001) ? 16'h0000 : tcnt + 16'h0001;
                    if (tcnt == dlen - 16'h0001) tst <= T_TAIL;
                end
                T_TAIL: if (last_bit) begin
                    tcnt <= tcnt + 16'h0001;
                    if (tcnt == TAIL_SYMS - 16'h0001) tst <= T_DONE;
                end
                default: ;
            endcase
        end
    end
end

// ****************************************
// receiver: differential decode, descramble, delimiter and header check
// ****************************************
reg [2:0] rst, next_rst;
reg [15:0] rcnt, next_rcnt;
reg [6:0] dsc, next_dsc;
reg [15:0] sfd_sr, next_sfd;
reg [47:0] hdr, next_hdr;
reg rshort, next_rshort, next_tout;
reg [1:0] nb, ob;
reg [1:0] rph_prev;
reg hold, hbit;
reg ib, db;
integer k;
wire [1:0] rp = {rx_sym_q, rx_sym_i ^ rx_sym_q};
wire [1:0] rd0 = rp - rph_prev;
wire [1:0] rd = rot_sense[`RX_REV_BIT] ? 2'h0 - rd0 : rd0;
wire rx_two = (rst == R_HDR && rshort) || (rst == R_DATA && rx_rate != `RATE_1M);
wire crc_ok = rev16(crc_calc(hdr[31:0])) == hdr[47:32];
wire sig_ok = hdr[7:2] == 6'h00;
assign stat_set[`CRC_ERR_BIT] = rxe2 & (rst == R_CHK) & ~crc_ok;
assign stat_set[`SIG_ERR_BIT] = rxe2 & (rst == R_CHK) & crc_ok & ~sig_ok;
assign stat_set[`TOUT_BIT] = rxe2 & next_tout;

always @* begin
    next_rst = rst;
    next_rcnt = rcnt;
    next_dsc = dsc;
    next_sfd = sfd_sr;
    next_hdr = hdr;
    next_rshort = rshort;
    next_tout = 1'b0;
    nb = 2'h0;
    ob = 2'h0;
    ib = 1'b0;
    db = 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
        if (rx_sym_valid && (k == 0 || rx_two)) begin
            ib = (k == 0) ? rd[1] : rd[1] ^ rd[0];
            db = scr_dis ? ib : ib ^ next_dsc[3] ^ next_dsc[6];
            next_dsc = {next_dsc[5:0], ib};
            case (next_rst)
                R_INIT: begin
                    next_rcnt = (next_rcnt == `INIT_LAST) ? 16'h0000 : next_rcnt + 16'h0001;
                    if (next_rcnt == 16'h0000) next_rst = R_SFD;
                end
                R_SFD: begin
                    next_sfd = {db, next_sfd[15:1]};
                    if (next_rcnt == 16'h0000) next_rshort = ~db;
                    if (next_sfd == SFD_VALUE || next_sfd == rev16(SFD_VALUE)) begin
                        next_rshort = next_sfd != SFD_VALUE;
                        next_rst = R_HDR;
                        next_rcnt = 16'h0000;
                    end else if (next_rcnt >= {8'h00, next_rshort ? short_len : long_len} + `SFD_MARGIN) begin
                        next_rst = R_IDLE;
                        next_tout = 1'b1;
                    end else begin
                        next_rcnt = next_rcnt + 16'h0001;
                    end
                end
                R_HDR: begin
                    next_hdr = {db, next_hdr[47:1]};
                    next_rcnt = next_rcnt + 16'h0001;
                    if (next_rcnt == `HDR_LAST + 16'h0001) next_rst = R_CHK;
                end
                R_DATA: begin
                    ob[k] = db;
                    nb = nb + 2'h1;
                end
                default: ;
            endcase
        end
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        rst <= R_IDLE;
        rcnt <= 16'h0000;
        dsc <= 7'h00;
        sfd_sr <= 16'h0000;
        hdr <= 48'h000000000000;
        rshort <= 1'b0;
        rph_prev <= 2'h0;
        hold <= 1'b0;
        hbit <= 1'b0;
        rx_data_bit <= 1'b0;
        rx_data_valid <= 1'b0;
        rx_data_ready <= 1'b0;
        rx_rate <= `RATE_1M;
    end else if (ce) begin
        if (rx_sym_valid) rph_prev <= rp;
        rx_data_valid <= 1'b0;
        hold <= 1'b0;
        if (hold) begin
            rx_data_bit <= hbit;
            rx_data_valid <= 1'b1;
        end else if (nb != 2'h0 && rxe2) begin
            rx_data_bit <= ob[0];
            rx_data_valid <= 1'b1;
            hold <= nb == 2'h2;
            hbit <= ob[1];
        end
        if (!rxe2) begin
            // the controller ends the packet by dropping enable
            rst <= R_IDLE;
            rx_data_ready <= 1'b0;
        end else if (rst == R_IDLE) begin
            if (rx_acquired) begin
                rst <= R_INIT;
                rcnt <= 16'h0000;
                sfd_sr <= 16'h0000;
            end
        end else if (rst == R_CHK) begin
            if (crc_ok && sig_ok) begin
                rx_rate <= hdr[1:0];
                rx_data_ready <= 1'b1;
                rst <= R_DATA;
            end else begin
                rx_data_ready <= 1'b0;
                rst <= R_IDLE;
            end
        end else begin
            rst <= next_rst;
            rcnt <= next_rcnt;
            dsc <= next_dsc;
            sfd_sr <= next_sfd;
            hdr <= next_hdr;
            rshort <= next_rshort;
        end
    end
end

endmodule // dsss_plcp_framer_scrambler

// ---- dsss_plcp_checker.sv ----
/* Port-level checks for the framer: bus answers, enable shutdown, receive bit timing.
   Assumes binding into dsss_plcp_framer_scrambler with one clock aclk and sync reset aresetn. */
`timescale 1ns/1ns
module dsss_plcp_checker (
    input logic aclk,
    input logic aresetn,
    input logic awready,
    input logic bvalid,
    input logic bready,
    input logic arvalid,
    input logic arready,
    input logic rvalid,
    input logic rready,
    input logic transmit_enable,
    input logic tx_chip_valid,
    input logic receive_enable,
    input logic rx_data_ready,
    input logic rx_sym_valid,
    input logic rx_data_valid
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // five low cycles cover the two-stage sync plus the registered chip output
    sequence s_tx_low; !transmit_enable [*5]; endsequence
    sequence s_rx_low; !receive_enable [*4]; endsequence
    property p_bhold; bvalid && !bready |=> bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write response withdrawn early");
    property p_bdone; bvalid && bready |=> !bvalid; endproperty
    a_bdone: assert property (p_bdone) else $error("write response repeated");
    property p_rhold; rvalid && !rready |=> rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("read response withdrawn early");
    property p_rans; arvalid && arready |=> rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_noaw; bvalid |-> !awready; endproperty
    a_noaw: assert property (p_noaw) else $error("write taken with response pending");
    property p_noar; rvalid |-> !arready; endproperty
    a_noar: assert property (p_noar) else $error("read taken with response pending");
    property p_txoff; s_tx_low |=> !tx_chip_valid; endproperty
    a_txoff: assert property (p_txoff) else $error("chips sent without enable");
    property p_rxoff; s_rx_low |=> !rx_data_ready; endproperty
    a_rxoff: assert property (p_rxoff) else $error("data ready without enable");
    property p_rxbit; rx_data_valid |-> $past(rx_sym_valid) || $past(rx_data_valid); endproperty
    a_rxbit: assert property (p_rxbit) else $error("receive bit without symbol");
endmodule // dsss_plcp_checker

bind dsss_plcp_framer_scrambler dsss_plcp_checker chk_i (.aclk, .aresetn, .awready, .bvalid, .bready, .arvalid,
    .arready, .rvalid, .rready, .transmit_enable, .tx_chip_valid, .receive_enable, .rx_data_ready, .rx_sym_valid,
    .rx_data_valid);

// ---- mac_partner.sv ----
/* Controller-side model: transmit enable and payload bits, counts payload fetches.
   Assumes the bench raises go to start a packet and lowers it to end one. */
`timescale 1ns/1ns
module mac_partner (
    input logic aclk,
    input logic go,
    input logic tx_data_req,
    output logic transmit_enable,
    output logic tx_data_bit,
    output logic [15:0] reqs
);
    // ****************************************
    // payload source
    // ****************************************
    logic [15:0] pat = 16'hB38D;
    assign transmit_enable = go;
    // outside a fetch the line shows the inverse so a stale sample is caught
    assign tx_data_bit = tx_data_req ? pat[0] : ~pat[0];
    always @(posedge aclk) begin
        if (!go) reqs <= 16'h0;
        else if (tx_data_req) reqs <= reqs + 16'h1;
        if (tx_data_req) pat <= {pat[0], pat[15:1]};
    end
endmodule // mac_partner

// ---- test_dsss_plcp_framer_scrambler.sv ----
/* Self-checking bench: registers over AXI4-Lite, header reception, transmit framing.
   Assumes the checker and the controller model are compiled beforehand. */
`timescale 1ns/1ns
`include "dsss_plcp_defs.vh"
module test_dsss_plcp_framer_scrambler;
    // ****************************************
    // signals, tasks, sequence
    // ****************************************
    localparam logic [15:0] SFD = `SFD_LONG;
    logic aclk = '0, aresetn = '0, ce = '1, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic go = '0, receive_enable = '0, rx_acquired = '0, rx_sym_valid = '0, rx_sym_i = '0, rx_sym_q = '0, ph = '0;
    logic [3:0] wstrb = '1;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rv, v;
    logic [1:0] rr;
    logic [6:0] sc = '0;
    logic scr = '0;
    wire awready, wready, arready, bvalid, rvalid, tx_data_req, tx_i, tx_q, tx_chip_valid;
    wire rx_data_bit, rx_data_valid, rx_data_ready, transmit_enable, tx_data_bit;
    wire [1:0] bresp, rresp, rx_rate;
    wire [31:0] rdata;
    wire [15:0] reqs;
    int n_fail = 0, check_count = 0, mon = 0;
    logic [7:0] ra [4] = '{`A_SHORT_LEN, `A_LONG_LEN, `A_LONG_SEED, `A_SHORT_SEED};
    logic [31:0] re [4] = '{32'h38, 32'h80, 32'h1B, 32'h6C};
    logic [7:0] wa [5] = '{`A_SHORT_LEN, `A_LONG_LEN, `A_SERVICE, `A_LEN_HIGH, `A_LEN_LOW};
    dsss_plcp_framer_scrambler dsss_plcp_framer_scrambler_i (.*);
    mac_partner mac_partner_i (.*);
    initial forever #25 aclk = ~aclk;
    task automatic chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // handshakes are judged at the falling edge, where inputs and outputs are settled
    task automatic bus(input w, input [7:0] a, input [31:0] d);
        logic ta, tw, tb;
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        arvalid <= !w;
        bready <= w;
        rready <= !w;
        do begin
            @(negedge aclk);
            ta = (awvalid & awready) | (arvalid & arready);
            tw = wvalid & wready;
            tb = w ? bvalid : rvalid;
            rr = w ? bresp : rresp;
            rv = rdata;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (ta) arvalid <= 0;
            if (tw) wvalid <= 0;
        end while (tb !== 1'b1);
        bready <= 0;
        rready <= 0;
        @(posedge aclk);
    endtask
    task automatic sym(input b);
        logic o;
        o = b ^ (scr & (sc[3] ^ sc[6]));
        sc = {sc[5:0], o};
        ph = ph ^ o;
        rx_sym_i <= ph;
        rx_sym_q <= ph;
        rx_sym_valid <= 1;
        @(posedge aclk);
        rx_sym_valid <= 0;
        @(negedge aclk);
        if (rx_data_ready === 1'b1) chk({rx_data_valid, rx_data_bit}, {1'b1, b});
        repeat (3) @(posedge aclk);
    endtask
    task automatic pkt(input [1:0] rt, input bad);
        logic [15:0] c;
        logic [31:0] h;
        c = `CRC_INIT;
        h = {16'($urandom), 8'h04, 6'h00, rt};
        for (int k = 0; k < 32; k++) c = {c[14:0], 1'b0} ^ ((h[k] ^ c[15]) ? `CRC_POLY : 16'h0);
        receive_enable <= 0;
        repeat (4) @(posedge aclk);
        receive_enable <= 1;
        rx_acquired <= 1;
        repeat (4) @(posedge aclk);
        repeat (15) sym(1);
        for (int k = 0; k < 16; k++) sym(SFD[k]);
        for (int k = 0; k < 32; k++) sym(h[k]);
        for (int k = 15; k >= 0; k--) sym(~c[k] ^ (bad && k == 0));
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk(rx_data_ready, !bad);
        if (!bad) chk(rx_rate, rt);
        @(posedge aclk);
        if (!bad && rt == 2'h0) repeat (8) sym(1'($urandom));
    endtask
    always @(negedge aclk) if (mon != 0 && tx_chip_valid === 1'b1) chk(tx_i, tx_q);
    initial begin
        #2000000;
        n_fail++;
        final_report;
    end
    initial begin
        void'($urandom(32'h6337));
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        for (int k = 0; k < 4; k++) begin
            bus(0, ra[k], 0);
            chk(rv, re[k]);
        end
        for (int k = 0; k < 5; k++) begin
            v = $urandom;
            bus(1, wa[k], v);
            bus(0, wa[k], 0);
            chk(rv, v[7:0]);
        end
        bus(1, 8'h40, 1);
        chk(rr, `RESP_SLVERR);
        bus(0, 8'h40, 0);
        chk(rr, `RESP_SLVERR);
        // delimiter time-out scales with this length, so keep it long for reception
        bus(1, `A_LONG_LEN, 32'h80);
        bus(1, `A_SCR_CTRL, 32'h4);
        for (int k = 0; k < 4; k++) begin
            pkt(k[1:0], 0);
            bus(0, `A_RX_SIGNAL, 0);
            chk(rv, k << 6);
        end
        scr = 1;
        bus(1, `A_SCR_CTRL, 0);
        pkt(2'h0, 0);
        pkt(2'h1, 1);
        bus(0, `A_RX_HDR_STAT, 0);
        chk(rv[2], 1);
        bus(1, `A_LONG_LEN, 4);
        bus(1, `A_LEN_HIGH, 0);
        bus(1, `A_LEN_LOW, 3);
        for (int k = 0; k < 2; k++) begin
            bus(1, `A_TX_SETUP, k);
            mon = (k == 0);
            go <= 1;
            for (int t = 0; t < 4000 && reqs != 3 * (k + 1); t++) @(posedge aclk);
            repeat (200) @(posedge aclk);
            chk(reqs, 3 * (k + 1));
            go <= 0;
            mon = 0;
            repeat (10) @(posedge aclk);
        end
        final_report;
    end
endmodule // test_dsss_plcp_framer_scrambler
